/* File: inc/irqrs_pkg.sv */
// Constants, field positions and carrier types of the raw status block.
package irqrs_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_CORE_LIMIT = 16'h0161;
  localparam logic [15:0] ADDR_LOCK       = 16'h0D21;
  localparam logic [15:0] ADDR_CLK_OUT    = 16'h0D22;
  localparam logic [15:0] ADDR_SEQ_BOOT   = 16'h0D23;
  localparam logic [15:0] ADDR_OVER_A     = 16'h0D24;
  localparam logic [15:0] ADDR_OVER_B     = 16'h0D25;
  localparam logic [15:0] ADDR_UNDER      = 16'h0D26;
  localparam logic [15:0] ADDR_SPK        = 16'h0D28;
  localparam logic [15:0] ADDR_LINE       = 16'h0D40;
  localparam logic [15:0] ADDR_AON        = 16'h0D55;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POS_CORE_HIGH   = 0;
  localparam int POS_DYN_SIG     = 9;
  localparam int POS_RC_B_LOCK   = 8;
  localparam int POS_RC_A_LOCK   = 7;
  localparam int POS_UNDER_SUM   = 6;
  localparam int POS_OVER_SUM    = 5;
  localparam int POS_LOOP_B_LOCK = 3;
  localparam int POS_LOOP_A_LOCK = 2;
  localparam int POS_MAIN_SLOW   = 1;
  localparam int POS_SECOND_SLOW = 0;
  localparam int POS_HOST_ERR    = 12;
  localparam int POS_MIX_LOST    = 11;
  localparam int POS_SECOND_OFF  = 10;
  localparam int POS_MAIN_OFF    = 9;
  localparam int POS_ISO_A_CFG   = 8;
  localparam int POS_ISO_B_CFG   = 7;
  localparam int POS_EP_EN       = 14;
  localparam int POS_EP_DIS      = 13;
  localparam int POS_BOOT        = 8;
  localparam int POS_ASYNC_CFG   = 3;
  localparam int POS_LOOP_B_OK   = 1;
  localparam int POS_LOOP_A_OK   = 0;
  localparam int POS_SPK_OFF     = 14;
  localparam int POS_SPK_R_SHORT = 13;
  localparam int POS_SPK_L_SHORT = 12;
  localparam int POS_LINE_TWO    = 1;
  localparam int POS_LINE_ONE    = 0;
  localparam int POS_MIC_CLAMP   = 3;
  localparam int POS_GPIN_FIVE   = 2;
  localparam int POS_JACK        = 0;

  // ----------------------------------------------------------------------
  // Reset values, codes and counts
  // ----------------------------------------------------------------------
  localparam logic       CORE_LIMIT_RST = 1'b0;
  localparam logic [2:0] RATE_CODE_CAP  = 3'h2;
  localparam logic [4:0] SLOT_ON_SECOND = 5'h18;
  localparam int         FLAG_W         = 112;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         BOOT_TIME_NS   = 2000;
  localparam int         BOOT_CYCLES    =
    (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] BOOT_CNT_MAX  = 12'(BOOT_CYCLES);

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } irqrs_reg_req_t;

  typedef struct packed {
    logic loop_a_locked;
    logic loop_b_locked;
    logic loop_a_clk_ok;
    logic loop_b_clk_ok;
    logic rate_conv_a_locked;
    logic rate_conv_b_locked;
    logic main_clk_slow_error;
    logic second_clk_slow_error;
    logic main_clk_enable;
    logic main_clk_running;
    logic second_clk_enable;
    logic second_clk_running;
  } irqrs_clk_stat_t;

  typedef struct packed {
    logic host_port_error;
    logic mixer_lost_sample;
    logic iso_conv_a_cfg_error;
    logic iso_conv_b_cfg_error;
    logic async_conv_cfg_error;
    logic dynamics_signal_seen;
  } irqrs_err_stat_t;

  typedef struct packed {
    logic [12:0] over_a;
    logic [8:0]  over_b;
    logic [9:0]  under;
    logic        spdif_over;
  } irqrs_rate_err_t;

  typedef struct packed {
    logic speaker_off_flag;
    logic right_speaker_short;
    logic left_speaker_short;
    logic mic_clamp_active;
  } irqrs_spk_stat_t;

endpackage : irqrs_pkg

/* File: hdl/irqrs_sync3.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module irqrs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_out <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule : irqrs_sync3

/* File: hdl/irqrs_top.sv */
// Raw interrupt status, interrupt line status and core clock limit.
//
// What this block does
// - Line two status is OR of unmasked flags.
// - Line one status is OR of unmasked flags.
// - Summary overrate bit follows any overrate bit.
// - Summary underrate bit follows any underrate bit.
// - One overrate status bit per subsystem.
// - Per-subsystem underrate bits plus serial overrate.
// - Main clock off flag reports disabled clock.
// - Second clock off flag; host waits on it.
// - Startup flag low during boot, then high.
// - Enable and disable sequence done bits per output.
// - Live lock bits for loops and converters, clock-ok bits for loops only.
// - Separate slow-clock errors for both clocks.
// - Speaker off flag and per-channel short bits.
// - Jack present when sense input is low.
// - Mic clamp bit 3, input five bit 2.
// - Live error bits for interface, mixer, converters.
// - Limit clear caps core rate at lower figure.
// - Higher core rate only with limit set.
// - Two unsynchronised domains, five rate slots mapped.
`timescale 1ns/1ps
module irqrs_top
  import irqrs_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Register port
  input  wire irqrs_reg_req_t      reg_req,
  output logic [15:0]              reg_rdata,
  output logic                     reg_rvalid,
  // Live conditions from the core
  input  wire irqrs_clk_stat_t     clk_stat,
  input  wire irqrs_err_stat_t     err_stat,
  input  wire irqrs_rate_err_t     rate_err,
  input  wire irqrs_spk_stat_t     spk_stat,
  input  wire logic [4:0]          out_enable_done,
  input  wire logic [4:0]          out_disable_done,
  // Pins
  input  wire logic                jack_sense_input,
  input  wire logic                gpin_five_pin,
  // Latched flags and masks
  input  wire logic [FLAG_W-1:0]   latched_irq_flag_group_one,
  input  wire logic [FLAG_W-1:0]   irq_mask_group_one,
  input  wire logic [FLAG_W-1:0]   latched_irq_flag_group_two,
  input  wire logic [FLAG_W-1:0]   irq_mask_group_two,
  // Core clocking
  input  wire logic [2:0]          main_clk_rate_code,
  output logic                     core_rate_high_select,
  output logic [2:0]               core_rate_code,
  output logic [4:0]               rate_slot_on_second_clk,
  // Summary outputs
  output logic                     line_one_asserted,
  output logic                     line_two_asserted,
  output logic                     startup_complete_flag
);

  // ----------------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------------
  logic        jack_level;
  logic        gpin_five_state;
  logic        main_clk_off_flag_reg;
  logic        second_clk_off_flag_reg;
  logic [11:0] boot_cnt_reg;
  logic        summary_overrate_error;
  logic        summary_underrate_error;
  logic        jack_present_flag;
  logic [15:0] rd_word_next;
  logic        core_write;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  irqrs_sync3 #(.RST_VAL(1'b1)) u_jack_sync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_in    (jack_sense_input),
    .level_out (jack_level)
  );

  irqrs_sync3 #(.RST_VAL(1'b0)) u_gpin_sync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_in    (gpin_five_pin),
    .level_out (gpin_five_state)
  );

  assign jack_present_flag = ~jack_level;

  // ----------------------------------------------------------------------
  // Summary error bits
  // ----------------------------------------------------------------------
  assign summary_overrate_error = (|rate_err.over_a) | (|rate_err.over_b)
                                | rate_err.spdif_over;
  assign summary_underrate_error = |rate_err.under;

  // ----------------------------------------------------------------------
  // Interrupt line status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      line_two_asserted <= 1'b0;
    end else begin
      line_two_asserted <= |(latched_irq_flag_group_two
                             & ~irq_mask_group_two);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      line_one_asserted <= 1'b0;
    end else begin
      line_one_asserted <= |(latched_irq_flag_group_one
                             & ~irq_mask_group_one);
    end
  end

  // ----------------------------------------------------------------------
  // Clock shut-down flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      main_clk_off_flag_reg <= 1'b0;
    end else begin
      main_clk_off_flag_reg <= ~clk_stat.main_clk_enable
                             & ~clk_stat.main_clk_running;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      second_clk_off_flag_reg <= 1'b0;
    end else begin
      second_clk_off_flag_reg <= ~clk_stat.second_clk_enable
                               & ~clk_stat.second_clk_running;
    end
  end

  // ----------------------------------------------------------------------
  // Boot sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_cnt_reg <= 12'h000;
    end else if (boot_cnt_reg != BOOT_CNT_MAX) begin
      boot_cnt_reg <= boot_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      startup_complete_flag <= 1'b0;
    end else begin
      startup_complete_flag <= (boot_cnt_reg == BOOT_CNT_MAX);
    end
  end

  // ----------------------------------------------------------------------
  // Core clock limit
  // ----------------------------------------------------------------------
  assign core_write = reg_req.wr && (reg_req.addr == ADDR_CORE_LIMIT);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_rate_high_select <= CORE_LIMIT_RST;
    end else if (core_write) begin
      core_rate_high_select <= reg_req.wdata[POS_CORE_HIGH];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_rate_code <= 3'h0;
    end else if (core_rate_high_select) begin
      core_rate_code <= main_clk_rate_code;
    end else if (main_clk_rate_code > RATE_CODE_CAP) begin
      core_rate_code <= RATE_CODE_CAP;
    end else begin
      core_rate_code <= main_clk_rate_code;
    end
  end

  // Slots one to three follow the main clock, four and five the second.
  assign rate_slot_on_second_clk = SLOT_ON_SECOND;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word_next = 16'h0000;
    case (reg_req.addr)
      ADDR_CORE_LIMIT: rd_word_next[POS_CORE_HIGH] = core_rate_high_select;
      ADDR_LOCK: begin
        rd_word_next[POS_DYN_SIG]     = err_stat.dynamics_signal_seen;
        rd_word_next[POS_RC_B_LOCK]   = clk_stat.rate_conv_b_locked;
        rd_word_next[POS_RC_A_LOCK]   = clk_stat.rate_conv_a_locked;
        rd_word_next[POS_UNDER_SUM]   = summary_underrate_error;
        rd_word_next[POS_OVER_SUM]    = summary_overrate_error;
        rd_word_next[POS_LOOP_B_LOCK] = clk_stat.loop_b_locked;
        rd_word_next[POS_LOOP_A_LOCK] = clk_stat.loop_a_locked;
        rd_word_next[POS_MAIN_SLOW]   = clk_stat.main_clk_slow_error;
        rd_word_next[POS_SECOND_SLOW] = clk_stat.second_clk_slow_error;
      end
      ADDR_CLK_OUT: begin
        rd_word_next[POS_HOST_ERR]   = err_stat.host_port_error;
        rd_word_next[POS_MIX_LOST]   = err_stat.mixer_lost_sample;
        rd_word_next[POS_SECOND_OFF] = second_clk_off_flag_reg;
        rd_word_next[POS_MAIN_OFF]   = main_clk_off_flag_reg;
        rd_word_next[POS_ISO_A_CFG]  = err_stat.iso_conv_a_cfg_error;
        rd_word_next[POS_ISO_B_CFG]  = err_stat.iso_conv_b_cfg_error;
        rd_word_next[3:0]            = out_enable_done[3:0];
      end
      ADDR_SEQ_BOOT: begin
        rd_word_next[POS_EP_EN]     = out_enable_done[4];
        rd_word_next[POS_EP_DIS]    = out_disable_done[4];
        rd_word_next[12:9]          = out_disable_done[3:0];
        rd_word_next[POS_BOOT]      = startup_complete_flag;
        rd_word_next[POS_ASYNC_CFG] = err_stat.async_conv_cfg_error;
        rd_word_next[POS_LOOP_B_OK] = clk_stat.loop_b_clk_ok;
        rd_word_next[POS_LOOP_A_OK] = clk_stat.loop_a_clk_ok;
      end
      ADDR_OVER_A: begin
        rd_word_next = {1'b0, rate_err.over_a[12:7], 1'b0,
                        rate_err.over_a[6:4], 1'b0,
                        rate_err.over_a[3:0]};
      end
      ADDR_OVER_B: begin
        rd_word_next = {rate_err.over_b[8:2], 7'h00,
                        rate_err.over_b[1:0]};
      end
      ADDR_UNDER: begin
        rd_word_next = {rate_err.spdif_over, 4'h0, rate_err.under[9:7],
                        1'b0, rate_err.under[6:0]};
      end
      ADDR_SPK: begin
        rd_word_next[POS_SPK_OFF]     = spk_stat.speaker_off_flag;
        rd_word_next[POS_SPK_R_SHORT] = spk_stat.right_speaker_short;
        rd_word_next[POS_SPK_L_SHORT] = spk_stat.left_speaker_short;
      end
      ADDR_LINE: begin
        rd_word_next[POS_LINE_TWO] = line_two_asserted;
        rd_word_next[POS_LINE_ONE] = line_one_asserted;
      end
      ADDR_AON: begin
        rd_word_next[POS_MIC_CLAMP] = spk_stat.mic_clamp_active;
        rd_word_next[POS_GPIN_FIVE] = gpin_five_state;
        rd_word_next[POS_JACK]      = jack_present_flag;
      end
      default: rd_word_next = 16'h0000;
    endcase
  end

  // Reads only sample the live word; nothing is cleared by them.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_word_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence main_off_req_s;
    !clk_stat.main_clk_enable && !clk_stat.main_clk_running;
  endsequence

  sequence lock_read_s;
    reg_req.rd && (reg_req.addr == ADDR_LOCK);
  endsequence

  line_two_or_a: assert property (
    |(latched_irq_flag_group_two & ~irq_mask_group_two)
      |=> line_two_asserted)
    else $error("line two status missed an unmasked flag");

  line_one_or_a: assert property (
    !(|(latched_irq_flag_group_one & ~irq_mask_group_one))
      |=> !line_one_asserted)
    else $error("line one status set without unmasked flag");

  over_summary_a: assert property (
    lock_read_s and (summary_overrate_error && |rate_err.over_b)
      |=> reg_rdata[POS_OVER_SUM] && reg_rvalid)
    else $error("summary overrate bit not read as set");

  under_summary_a: assert property (
    lock_read_s and (rate_err.under == 10'h000)
      |=> !reg_rdata[POS_UNDER_SUM])
    else $error("summary underrate bit set with no cause");

  main_off_a: assert property (
    main_off_req_s ##1 main_off_req_s |-> main_clk_off_flag_reg)
    else $error("main clock off flag not reported");

  second_on_a: assert property (
    clk_stat.second_clk_enable |=> !second_clk_off_flag_reg)
    else $error("second clock off flag set while enabled");

  boot_wait_a: assert property (
    startup_complete_flag |-> $past(boot_cnt_reg) == BOOT_CNT_MAX)
    else $error("startup flag raised before boot count ended");

  core_cap_a: assert property (
    !core_rate_high_select && (main_clk_rate_code > RATE_CODE_CAP)
      |=> core_rate_code == RATE_CODE_CAP)
    else $error("core rate not capped with limit clear");

  core_high_a: assert property (
    core_rate_high_select
      |=> core_rate_code == $past(main_clk_rate_code))
    else $error("core rate not passed through with limit set");

  ro_write_a: assert property (
    reg_req.wr && (reg_req.addr != ADDR_CORE_LIMIT)
      |=> $stable(core_rate_high_select))
    else $error("write to read-only offset changed state");

  jack_read_a: assert property (
    reg_req.rd && (reg_req.addr == ADDR_AON) && !jack_level
      |=> reg_rdata[POS_JACK])
    else $error("jack present not reported on low sense level");
endmodule : irqrs_top

/* File: tb/test_irq_raw_status_and_core_clock_limit.sv */
// Self-checking testbench for the raw status and core clock limit block.
`timescale 1ns/1ps
module test_irq_raw_status_and_core_clock_limit
  import irqrs_pkg::*;
;
  // ------------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------------
  logic              clk_sys;
  logic              rstn;
  irqrs_reg_req_t    reg_req;
  logic [15:0]       reg_rdata;
  logic              reg_rvalid;
  irqrs_clk_stat_t   clk_stat;
  irqrs_err_stat_t   err_stat;
  irqrs_rate_err_t   rate_err;
  irqrs_spk_stat_t   spk_stat;
  logic [4:0]        out_enable_done;
  logic [4:0]        out_disable_done;
  logic              jack_sense_input;
  logic              gpin_five_pin;
  logic [FLAG_W-1:0] flag_one;
  logic [FLAG_W-1:0] mask_one;
  logic [FLAG_W-1:0] flag_two;
  logic [FLAG_W-1:0] mask_two;
  logic [2:0]        main_clk_rate_code;
  logic              core_rate_high_select;
  logic [2:0]        core_rate_code;
  logic [4:0]        rate_slot_on_second_clk;
  logic              line_one_asserted;
  logic              line_two_asserted;
  logic              startup_complete_flag;
  int                n_mismatch;
  int                total_checks;
  logic [32:0]       single_err [4];

  irqrs_top uut (
    .clk_sys                    (clk_sys),
    .rstn                       (rstn),
    .reg_req                    (reg_req),
    .reg_rdata                  (reg_rdata),
    .reg_rvalid                 (reg_rvalid),
    .clk_stat                   (clk_stat),
    .err_stat                   (err_stat),
    .rate_err                   (rate_err),
    .spk_stat                   (spk_stat),
    .out_enable_done            (out_enable_done),
    .out_disable_done           (out_disable_done),
    .jack_sense_input           (jack_sense_input),
    .gpin_five_pin              (gpin_five_pin),
    .latched_irq_flag_group_one (flag_one),
    .irq_mask_group_one         (mask_one),
    .latched_irq_flag_group_two (flag_two),
    .irq_mask_group_two         (mask_two),
    .main_clk_rate_code         (main_clk_rate_code),
    .core_rate_high_select      (core_rate_high_select),
    .core_rate_code             (core_rate_code),
    .rate_slot_on_second_clk    (rate_slot_on_second_clk),
    .line_one_asserted          (line_one_asserted),
    .line_two_asserted          (line_two_asserted),
    .startup_complete_flag      (startup_complete_flag)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : settle

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_req.addr = a;
    reg_req.rd   = 1'b1;
    @(negedge clk_sys);
    reg_req.rd   = 1'b0;
    chk("read valid", 16'h0001, {15'h0, reg_rvalid});
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_req.addr  = a;
    reg_req.wdata = d;
    reg_req.wr    = 1'b1;
    @(negedge clk_sys);
    reg_req.wr    = 1'b0;
  endtask : wr

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ------------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rstn = 1'b0;
    reg_req = '0;
    clk_stat = '0;
    err_stat = '0;
    rate_err = '0;
    spk_stat = '0;
    out_enable_done = '0;
    out_disable_done = '0;
    jack_sense_input = 1'b1;
    gpin_five_pin = 1'b0;
    flag_one = '0;
    mask_one = '0;
    flag_two = '0;
    mask_two = '0;
    main_clk_rate_code = 3'h3;
    single_err = '{33'h1_0000_0000, 33'h0_0000_0800, 33'h1, 33'h2};
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    chk("boot flag", 16'h0, {15'h0, startup_complete_flag});
    chk("rate slots", {11'h0, SLOT_ON_SECOND},
        {11'h0, rate_slot_on_second_clk});
    rd(ADDR_CORE_LIMIT, 16'h0000);
    rd(ADDR_SEQ_BOOT, 16'h0000);
    rd(ADDR_AON, 16'h0000);
    chk("capped rate", {13'h0, RATE_CODE_CAP},
        {13'h0, core_rate_code});
    settle(150);
    chk("boot flag", 16'h0, {15'h0, startup_complete_flag});
    settle(110);
    chk("boot flag", 16'h1, {15'h0, startup_complete_flag});
    $display("test boot done");
    wr(ADDR_CORE_LIMIT, 16'h0001);
    settle(2);
    chk("high select", 16'h1, {15'h0, core_rate_high_select});
    chk("core rate", 16'h3, {13'h0, core_rate_code});
    rd(ADDR_CORE_LIMIT, 16'h0001);
    wr(ADDR_CORE_LIMIT, 16'h0000);
    settle(2);
    chk("core rate", {13'h0, RATE_CODE_CAP},
        {13'h0, core_rate_code});
    main_clk_rate_code = 3'h1;
    settle(2);
    chk("core rate", 16'h1, {13'h0, core_rate_code});
    $display("test core limit done");
    clk_stat = 12'hFFF;
    err_stat = 6'h3F;
    out_enable_done = 5'h1F;
    out_disable_done = 5'h1F;
    settle(2);
    rd(ADDR_LOCK, 16'h038F);
    rd(ADDR_CLK_OUT, 16'h198F);
    rd(ADDR_SEQ_BOOT, 16'h7F0B);
    clk_stat = '0;
    err_stat = '0;
    out_enable_done = '0;
    out_disable_done = '0;
    settle(2);
    rd(ADDR_CLK_OUT, 16'h0600);
    rd(ADDR_LOCK, 16'h0000);
    $display("test live status done");
    rate_err = {13'h1FFF, 9'h1FF, 10'h3FF, 1'b1};
    settle(2);
    rd(ADDR_OVER_A, 16'h7EEF);
    rd(ADDR_OVER_B, 16'hFE03);
    rd(ADDR_UNDER, 16'h877F);
    rd(ADDR_LOCK, 16'h0060);
    for (int i = 0; i < 4; i++) begin
      rate_err = single_err[i];
      settle(2);
      rd(ADDR_LOCK, (i == 3) ? 16'h0040 : 16'h0020);
    end
    rate_err = '0;
    wr(ADDR_OVER_A, 16'hFFFF);
    settle(2);
    chk("high select", 16'h0, {15'h0, core_rate_high_select});
    rd(ADDR_OVER_A, 16'h0000);
    rd(16'h0D30, 16'h0000);
    $display("test rate errors done");
    flag_two[FLAG_W-1] = 1'b1;
    settle(2);
    chk("line two", 16'h1, {15'h0, line_two_asserted});
    rd(ADDR_LINE, 16'h0002);
    rd(ADDR_LINE, 16'h0002);
    mask_two[FLAG_W-1] = 1'b1;
    flag_one[0] = 1'b1;
    settle(2);
    chk("line two", 16'h0, {15'h0, line_two_asserted});
    chk("line one", 16'h1, {15'h0, line_one_asserted});
    rd(ADDR_LINE, 16'h0001);
    mask_one[0] = 1'b1;
    settle(2);
    chk("line one", 16'h0, {15'h0, line_one_asserted});
    $display("test interrupt lines done");
    spk_stat = 4'hF;
    jack_sense_input = 1'b0;
    gpin_five_pin = 1'b1;
    settle(8);
    rd(ADDR_SPK, 16'h7000);
    rd(ADDR_AON, 16'h000D);
    spk_stat = '0;
    jack_sense_input = 1'b1;
    gpin_five_pin = 1'b0;
    settle(8);
    rd(ADDR_SPK, 16'h0000);
    rd(ADDR_AON, 16'h0000);
    $display("test speaker and pins done");
    report_and_stop();
  end
endmodule : test_irq_raw_status_and_core_clock_limit
